/* File: hdl/buck_sequencing_protection_ctrl.sv */
// Sequencing, spread spectrum and protection logic of a buck converter.

// Function
// - Low bootstrap voltage: recharge via low side before any high-side turn-on.
// - Spread spectrum hops every cycle within plus/minus two percent, small steps.
// - Hop sequence repeats slower than 1.5 Hz.
// - Spread spectrum off in dropout, auto light load, min on-time, external sync.
// - Forced PWM keeps spread spectrum active even at zero load.
// - Soft start on lockout release, enable, hiccup wait end, thermal recovery.
// - Reference ramps so output reaches ninety percent after soft-start time.
// - Soft-start entry forces auto mode with diode emulation.
// - No forced PWM or hiccup in soft start until regulation or window limit.
// - Output sag starts recovery with reference one percent above output.
// - Recovery allows hiccup below 0.4 set point; dropout regulation inhibits it.
// - Recovery allows forced PWM so output can be pulled down.
// - Recovery ramp rises at the soft-start rate.
// - Loop holds feedback node at the one-volt reference.
// - After blanking, high-side current compared to lower of two limits.
// - Effective high-side limit falls with duty above thirty-five percent.
// - Low-side overcurrent at cycle end extends cycle until current drops.
// - After extension, high side waits for the next cycle start.
// - Hiccup after 128 consecutive cycles of all three entry conditions.
// - Hiccup stops switching, waits, then restarts soft start.
// - Overtemperature turns both switches off until cool, then soft start.
// - Thermal shutdown keeps supply regulator on at reduced current limit.
// - External sync valid 2048 cycles switches clock and ends spreading.
module buck_sequencing_protection_ctrl #(
   parameter int SS_COUNT = buck_seq_pkg::SS_CYCLES,
   parameter int SS2_COUNT = buck_seq_pkg::SS2_CYCLES,
   parameter int HICCUP_WAIT_COUNT = buck_seq_pkg::HICCUP_WAIT_CYCLES,
   parameter int SYNC_COUNT = buck_seq_pkg::SYNC_CYCLES,
   parameter bit SPREAD_OPTION = 1'b1,
   parameter bit FORCED_PWM_MODE_OPTION = 1'b1
) (
   // Clock, reset and clock enable.
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Enables and supply state.
   input wire logic enable_in,
   input wire logic undervoltage_lockout,
   // Oscillator and loop timing.
   input wire logic cycle_start,
   input wire logic pwm_off_cmd,
   input wire logic sync_valid,
   input wire logic min_on_time_slow,
   input wire logic min_off_dropout,
   input wire logic light_load,
   // Comparators and output level.
   input wire logic boot_below_undervoltage_lockout,
   input wire logic vout_in_reg,
   input wire logic vout_sag,
   input wire logic vout_below_40pct,
   input wire logic [11:0] vout_level,
   input wire logic hs_over_fixed,
   input wire logic hs_over_loop,
   input wire logic ls_over_limit,
   input wire logic temp_trip,
   input wire logic temp_cool,
   // Switch drives and mode outputs.
   output logic high_side_switch,
   output logic low_side_switch,
   output logic diode_emulation,
   output logic forced_pwm_mode,
   output logic hiccup_enabled,
   output logic [11:0] reference,
   output logic [3:0] hop_trim,
   output logic spread_active,
   output logic sync_locked,
   output logic ldo_reduced_limit,
   output logic soft_start_busy
);

   typedef struct packed {
      logic [15:0] cmp;
      logic [11:0] vlevel;
      buck_seq_pkg::seq_type st;
      buck_seq_pkg::phase_type ph;
      logic en_prev;
      logic undervoltage_lockout_prev;
      logic [23:0] ss_tmr;
      logic [23:0] wait_tmr;
      logic ss2_done;
      logic [11:0] ref_v;
      logic [7:0] hic_cnt;
      logic [22:0] lfsr;
      logic [3:0] hop;
      logic [11:0] sync_cnt;
      logic locked;
      logic [3:0] blank;
      logic hs_since_cycle;
      logic ls_ext;
      logic hs;
      logic ls;
   } state_type;

   state_type q, d;

   // Clocks per reference tick; the ramp reaches 90 percent by SS_COUNT.
   localparam int REF_SPAN = int'(buck_seq_pkg::REF_FULL);
   localparam int STEP_DIV = (SS_COUNT * 9) / (10 * REF_SPAN) > 0 ?
      (SS_COUNT * 9) / (10 * REF_SPAN) : 1;
   // Codes per tick: a short soft-start time needs more than one code per
   // clock, or the reference would still be low when the time is up.
   localparam int STEP_UP = (SS_COUNT * 9) / (10 * REF_SPAN) > 0 ? 1 :
      (REF_SPAN * 9 + 10 * SS_COUNT - 1) / (10 * SS_COUNT);

   // Next reference on a ramp tick, held at full scale.
   function automatic logic [11:0] ramp_step(input logic [11:0] r);
      logic [12:0] s;
      s = {1'b0, r} + 13'(STEP_UP);
      if (s > {1'b0, buck_seq_pkg::REF_FULL}) begin
         s = {1'b0, buck_seq_pkg::REF_FULL};
      end
      return s[11:0];
   endfunction

   logic [15:0] c;
   logic ramp_tick;
   logic hic_cond;
   logic hop_ok;

   assign c = q.cmp;
   // Order: sag,below40,inreg,hs_fix,hs_loop,ls,trip,cool,boot,sync,...
   assign ramp_tick = (q.ss_tmr % 24'(STEP_DIV)) == 24'h000000;
   assign hic_cond = c[1] && q.ss2_done && !c[11];
   assign hop_ok = SPREAD_OPTION && !q.locked && !c[11] && !c[10]
      && !(c[12] && !forced_pwm_mode);

   always_comb begin
      d = q;
      // Comparator and mode inputs taken into flops first, used one cycle later.
      d.cmp = {2'b00, enable_in, light_load, min_off_dropout,
         min_on_time_slow, sync_valid, boot_below_undervoltage_lockout, temp_cool, temp_trip,
         ls_over_limit, hs_over_loop, hs_over_fixed, vout_in_reg,
         vout_below_40pct, vout_sag};
      d.cmp = {c[15:14], d.cmp[13:0]};
      d.cmp = {2'b00, d.cmp[13:0]};
      d.cmp[13] = enable_in;
      d.cmp[12] = light_load;
      d.cmp[11] = min_off_dropout;
      d.cmp[10] = min_on_time_slow;
      d.cmp[9] = sync_valid;
      d.cmp[8] = boot_below_undervoltage_lockout;
      d.cmp[7] = temp_cool;
      d.cmp[6] = temp_trip;
      d.cmp[5] = ls_over_limit;
      d.cmp[4] = hs_over_loop;
      d.cmp[3] = hs_over_fixed;
      d.cmp[2] = vout_in_reg;
      d.cmp[1] = vout_below_40pct;
      d.cmp[0] = vout_sag;
      d.vlevel = vout_level;
      d.en_prev = c[13];
      d.undervoltage_lockout_prev = undervoltage_lockout;

      // External sync qualification.
      if (!c[9]) begin
         d.sync_cnt = 12'h000;
         d.locked = 1'b0;
      end else if (cycle_start && !q.locked) begin
         if (q.sync_cnt == 12'(SYNC_COUNT - 1)) begin
            d.locked = 1'b1;
         end else begin
            d.sync_cnt = q.sync_cnt + 12'h001;
         end
      end

      // Spread spectrum: LFSR steps each cycle, trim moves one step at most, or straight back to centre when spreading is off.
      if (cycle_start) begin
         d.lfsr = {q.lfsr[21:0], q.lfsr[buck_seq_pkg::LFSR_TAP_A]
            ^ q.lfsr[buck_seq_pkg::LFSR_TAP_B]};
         if (!hop_ok) begin
            d.hop = buck_seq_pkg::HOP_CENTRE;
         end else if (q.lfsr[0] && q.hop != 4'hF) begin
            d.hop = q.hop + buck_seq_pkg::HOP_MAX_STEP;
         end else if (!q.lfsr[0] && q.hop != 4'h0) begin
            d.hop = q.hop - buck_seq_pkg::HOP_MAX_STEP;
         end
      end

      // Sequencer timers.
      if (q.ss_tmr != 24'hFFFFFF) begin
         d.ss_tmr = q.ss_tmr + 24'h000001;
      end
      if (q.ss_tmr >= 24'(SS2_COUNT) || c[2]) begin
         d.ss2_done = 1'b1;
      end

      // Hiccup counter per switching cycle.
      if (cycle_start) begin
         if (!hic_cond || !hiccup_enabled) begin
            d.hic_cnt = 8'h00;
         end else if (q.hic_cnt != 8'hFF) begin
            d.hic_cnt = q.hic_cnt + 8'h01;
         end
      end

      unique case (q.st)
         buck_seq_pkg::ST_OFF: begin
            d.ref_v = buck_seq_pkg::REF_ZERO;
            if (c[13] && !undervoltage_lockout) begin
               d.st = buck_seq_pkg::ST_SOFT_START;
               d.ss_tmr = 24'h000000;
               d.ss2_done = 1'b0;
               d.ref_v = d.vlevel; // Start from present output.
            end
         end
         buck_seq_pkg::ST_SOFT_START, buck_seq_pkg::ST_RUN,
         buck_seq_pkg::ST_RECOVER: begin
            if (q.st != buck_seq_pkg::ST_RUN && ramp_tick) begin
               d.ref_v = ramp_step(q.ref_v);
            end
            if (q.st == buck_seq_pkg::ST_SOFT_START && q.ss2_done) begin
               d.st = buck_seq_pkg::ST_RUN;
            end
            if (q.st == buck_seq_pkg::ST_RUN && c[0] && !c[11]) begin
               d.st = buck_seq_pkg::ST_RECOVER;
               d.ref_v = q.vlevel + buck_seq_pkg::REF_ONE_PCT;
               // A saturated tick timer would stall the recovery ramp.
               d.ss_tmr = 24'h000000;
            end
            if (q.st == buck_seq_pkg::ST_RECOVER
               && q.ref_v == buck_seq_pkg::REF_FULL) begin
               d.st = buck_seq_pkg::ST_RUN;
            end
            if (cycle_start && q.hic_cnt == 8'(buck_seq_pkg::HICCUP_CYCLES - 1)
               && hic_cond && hiccup_enabled) begin
               d.st = buck_seq_pkg::ST_HICCUP;
               d.wait_tmr = 24'h000000;
               d.hic_cnt = 8'h00;
            end
            if (!c[13] || undervoltage_lockout) begin
               d.st = buck_seq_pkg::ST_OFF;
            end
         end
         buck_seq_pkg::ST_HICCUP: begin
            d.wait_tmr = q.wait_tmr + 24'h000001;
            if (q.wait_tmr == 24'(HICCUP_WAIT_COUNT - 1)) begin
               d.st = buck_seq_pkg::ST_SOFT_START;
               d.ss_tmr = 24'h000000;
               d.ss2_done = 1'b0;
               d.ref_v = q.vlevel;
            end
         end
         buck_seq_pkg::ST_THERMAL: begin
            if (c[7]) begin
               d.st = buck_seq_pkg::ST_SOFT_START;
               d.ss_tmr = 24'h000000;
               d.ss2_done = 1'b0;
               d.ref_v = q.vlevel;
            end
         end
      endcase
      if (c[6]) begin
         d.st = buck_seq_pkg::ST_THERMAL;
      end

      // Switch phase machine.
      if (q.blank != 4'h0) begin
         d.blank = q.blank - 4'h1;
      end
      if (cycle_start) begin
         d.hs_since_cycle = 1'b0;
      end
      unique case (q.ph)
         buck_seq_pkg::PH_IDLE: begin
            if (cycle_start) begin
               d.ph = c[8] ? buck_seq_pkg::PH_BOOT
                  : buck_seq_pkg::PH_HIGH;
            end
         end
         buck_seq_pkg::PH_BOOT: begin
            if (!c[8]) begin
               d.ph = buck_seq_pkg::PH_HIGH;
            end
         end
         buck_seq_pkg::PH_HIGH: begin
            if (q.blank == 4'h0 && (c[3] || c[4] || pwm_off_cmd)) begin
               d.ph = buck_seq_pkg::PH_LOW;
            end
         end
         buck_seq_pkg::PH_LOW: begin
            if (cycle_start && c[5]) begin
               d.ls_ext = 1'b1;
            end
            if (q.ls_ext && !c[5]) begin
               d.ls_ext = 1'b0;
               d.ph = buck_seq_pkg::PH_IDLE;
            end else if (cycle_start && !c[5] && !q.ls_ext) begin
               d.ph = c[8] ? buck_seq_pkg::PH_BOOT
                  : buck_seq_pkg::PH_HIGH;
            end
         end
      endcase
      if (d.ph == buck_seq_pkg::PH_HIGH && q.ph != buck_seq_pkg::PH_HIGH) begin
         d.blank = 4'(buck_seq_pkg::BLANK_CYCLES);
      end
      if (q.st == buck_seq_pkg::ST_OFF || q.st == buck_seq_pkg::ST_HICCUP
         || q.st == buck_seq_pkg::ST_THERMAL || c[6]) begin
         d.ph = buck_seq_pkg::PH_IDLE;
         d.ls_ext = 1'b0;
      end
      d.hs = d.ph == buck_seq_pkg::PH_HIGH;
      d.ls = d.ph == buck_seq_pkg::PH_LOW || d.ph == buck_seq_pkg::PH_BOOT;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '{cmp: 16'h0000, vlevel: 12'h000,
            st: buck_seq_pkg::ST_OFF, ph: buck_seq_pkg::PH_IDLE,
            en_prev: 1'b0, undervoltage_lockout_prev: 1'b0, ss_tmr: 24'h000000,
            wait_tmr: 24'h000000, ss2_done: 1'b0, ref_v: 12'h000,
            hic_cnt: 8'h00, lfsr: buck_seq_pkg::LFSR_SEED,
            hop: buck_seq_pkg::HOP_CENTRE, sync_cnt: 12'h000,
            locked: 1'b0, blank: 4'h0, hs_since_cycle: 1'b0,
            ls_ext: 1'b0, hs: 1'b0, ls: 1'b0};
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign high_side_switch = q.hs;
   assign low_side_switch = q.ls;
   assign soft_start_busy = q.st == buck_seq_pkg::ST_SOFT_START;
   // Soft start forces auto mode; recovery and run allow forced PWM.
   // Sync lock forces it as well, but never inside soft start.
   assign forced_pwm_mode = (FORCED_PWM_MODE_OPTION || q.locked)
      && !soft_start_busy;
   assign diode_emulation = !forced_pwm_mode;
   // Hiccup off in soft start until regulation or the window limit.
   assign hiccup_enabled = q.ss2_done && !soft_start_busy;
   assign reference = q.ref_v;
   assign hop_trim = q.hop;
   assign spread_active = hop_ok;
   assign sync_locked = q.locked;
   assign ldo_reduced_limit = q.st == buck_seq_pkg::ST_THERMAL;

endmodule

/* File: shared/buck_seq_pkg.sv */
// Shared constants and types for the buck sequencing and protection controller.
package buck_seq_pkg;

   // Clock period of sys_clk in nanoseconds.
   localparam int CLK_PERIOD_NS = 10;

   // Reference code: 1 V target on the feedback node maps to full scale.
   localparam int REF_W = 12;
   localparam logic [11:0] REF_ZERO = 12'h000;
   localparam logic [11:0] REF_FULL = 12'hFFF;
   // One percent of full scale, added above the present output in recovery.
   localparam logic [11:0] REF_ONE_PCT = 12'h029;

   // Hop band of plus or minus two percent, in period trim steps.
   localparam int HOP_W = 4;
   localparam logic [3:0] HOP_CENTRE = 4'h8;
   localparam logic [3:0] HOP_MAX_STEP = 4'h1;
   // Sequence length 2^23-1 cycles: above 3 s at 2.2 MHz, so below 1.5 Hz.
   localparam int LFSR_W = 23;
   localparam logic [22:0] LFSR_SEED = 23'h000001;
   localparam int LFSR_TAP_A = 22;
   localparam int LFSR_TAP_B = 17;

   // Hiccup needs this many consecutive qualifying switching cycles.
   localparam int HICCUP_CYCLES = 128;
   localparam int HICCUP_CNT_W = 8;
   // External sync must be valid for this many cycles before lock.
   localparam int SYNC_CYCLES = 2048;
   localparam int SYNC_CNT_W = 12;

   // Soft-start time, second soft-start limit and hiccup wait, in ns.
   localparam int SS_TIME_NS = 3_500_000;
   localparam int SS2_TIME_NS = 10_000_000;
   localparam int HICCUP_WAIT_NS = 50_000_000;
   localparam int SS_CYCLES = SS_TIME_NS / CLK_PERIOD_NS;
   localparam int SS2_CYCLES = SS2_TIME_NS / CLK_PERIOD_NS;
   localparam int HICCUP_WAIT_CYCLES = HICCUP_WAIT_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 24;

   // High-side blanking after turn-on, in ns, and as cycles rounded up.
   localparam int BLANK_NS = 50;
   localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_W = 4;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_SOFT_START,
      ST_RUN,
      ST_RECOVER,
      ST_HICCUP,
      ST_THERMAL
   } seq_type;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_BOOT,
      PH_HIGH,
      PH_LOW
   } phase_type;

endpackage

/* File: verif/buck_load_model.sv */
// Behavioural inductor and load at the switch node.
module buck_load_model #(
   parameter int SLOPE = 8,
   parameter int LIMIT = 24
) (
   // Clock and switch drives.
   input wire logic sys_clk,
   input wire logic high_side_switch,
   input wire logic low_side_switch,
   // Current comparator results.
   output logic hs_over_fixed,
   output logic hs_over_loop,
   output logic ls_over_limit
);
   // Current rises through the high side and decays slowly through the
   // low side; with both off the body diode clamps it to zero.
   int cur = 0;
   initial {hs_over_fixed, hs_over_loop, ls_over_limit} = 3'h0;
   always @(negedge sys_clk) begin
      if (high_side_switch) cur = cur + SLOPE;
      else if (low_side_switch && cur > 0) cur = cur - 1;
      else cur = 0;
      hs_over_fixed = high_side_switch && cur > 2 * LIMIT;
      hs_over_loop = high_side_switch && cur > LIMIT;
      ls_over_limit = low_side_switch && cur > LIMIT;
   end
endmodule

/* File: verif/buck_seq_chk.sv */
// Assertion checker for the buck sequencing and protection controller.
module buck_seq_chk #(
   parameter int SYNC_COUNT = 16
) (
   // Clock, reset and watched inputs.
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic cycle_start,
   input wire logic temp_trip,
   input wire logic sync_valid,
   input wire logic min_on_time_slow,
   input wire logic min_off_dropout,
   // Watched outputs.
   input wire logic high_side_switch,
   input wire logic low_side_switch,
   input wire logic diode_emulation,
   input wire logic forced_pwm_mode,
   input wire logic hiccup_enabled,
   input wire logic [11:0] reference,
   input wire logic [3:0] hop_trim,
   input wire logic spread_active,
   input wire logic sync_locked,
   input wire logic ldo_reduced_limit,
   input wire logic soft_start_busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Counts switching cycles with sync valid; any gap restarts the wait.
   int sync_run_q;
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) sync_run_q <= 0;
      else if (!sync_valid) sync_run_q <= 0;
      else if (clk_en && cycle_start) sync_run_q <= sync_run_q + 1;

   AST_THERM_OFF: assert property (
      temp_trip && clk_en ##1 clk_en [*3]
      |-> !high_side_switch && !low_side_switch)
      else $error("switch on after thermal trip");
   AST_LDO_OFF: assert property (
      ldo_reduced_limit ##1 ldo_reduced_limit
      |-> !high_side_switch && !low_side_switch)
      else $error("switching during reduced supply limit");
   AST_SS_MODE: assert property (
      soft_start_busy
      |-> diode_emulation && !forced_pwm_mode && !hiccup_enabled)
      else $error("wrong mode during soft start");
   AST_SS_RAMP: assert property (
      soft_start_busy && $past(soft_start_busy)
      |-> reference >= $past(reference))
      else $error("reference fell during soft start");
   // Three samples cover the input register with one to spare; spread_active is not registered.
   AST_SPREAD_SLOW: assert property (
      (clk_en && (min_on_time_slow || min_off_dropout)) [*3]
      |-> !spread_active)
      else $error("spreading while the clock is slowed");
   AST_SYNC_MODE: assert property (
      sync_locked
      |-> !spread_active && (forced_pwm_mode || soft_start_busy))
      else $error("spreading while locked to sync");
   AST_SYNC_EARLY: assert property (
      $rose(sync_locked) |-> sync_run_q >= SYNC_COUNT)
      else $error("sync lock too early");
   AST_SYNC_LATE: assert property (
      sync_run_q == SYNC_COUNT + 4 |-> sync_locked)
      else $error("sync lock missing");
   AST_HOP_STEP: assert property (
      spread_active && $past(spread_active) && hop_trim != $past(hop_trim)
      |-> (hop_trim == $past(hop_trim) + 4'h1)
      || (hop_trim == $past(hop_trim) - 4'h1))
      else $error("hop step larger than one trim step");

   COV_SS: cover property ($rose(soft_start_busy));
   COV_THERM: cover property ($rose(ldo_reduced_limit));
   COV_SYNC: cover property ($rose(sync_locked));
endmodule

bind buck_sequencing_protection_ctrl buck_seq_chk #(
   .SYNC_COUNT(SYNC_COUNT)
) buck_seq_chk_i (
   .sys_clk, .rstn, .clk_en, .cycle_start, .temp_trip, .sync_valid,
   .min_on_time_slow, .min_off_dropout, .high_side_switch,
   .low_side_switch, .diode_emulation, .forced_pwm_mode,
   .hiccup_enabled, .reference, .hop_trim, .spread_active,
   .sync_locked, .ldo_reduced_limit, .soft_start_busy
);

/* File: verif/buck_sequencing_protection_ctrl_bench.sv */
// Self-checking bench for the buck sequencing and protection controller.
module buck_sequencing_protection_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SS_N = 400;
   localparam int SS2_N = 1000;
   localparam int HW_N = 500;
   localparam int SYNC_N = 16;
   typedef struct packed {
      logic light, slow_on, drop, exp;
   } row_type;
   row_type rows [4] = '{4'h1, 4'h9, 4'h4, 4'h2};
   logic sys_clk = 1'h0, rstn = 1'h0, clk_en = 1'h1;
   logic enable_in = 1'h0, undervoltage_lockout = 1'h1;
   logic cycle_start = 1'h0, pwm_off_cmd = 1'h0, sync_valid = 1'h0;
   logic min_on_time_slow = 1'h0, min_off_dropout = 1'h0;
   logic light_load = 1'h0, boot_below_undervoltage_lockout = 1'h0;
   logic vout_in_reg = 1'h0, vout_sag = 1'h0, vout_below_40pct = 1'h0;
   logic [11:0] vout_level = 12'h000;
   logic temp_trip = 1'h0, temp_cool = 1'h1;
   logic hs_over_fixed, hs_over_loop, ls_over_limit;
   logic high_side_switch, low_side_switch, diode_emulation;
   logic forced_pwm_mode, hiccup_enabled, spread_active, sync_locked;
   logic ldo_reduced_limit, soft_start_busy;
   logic [11:0] reference;
   logic [3:0] hop_trim;
   int miscompares = 0, n_tests = 0, cyc = 0;

   buck_sequencing_protection_ctrl #(
      .SS_COUNT(SS_N), .SS2_COUNT(SS2_N), .HICCUP_WAIT_COUNT(HW_N),
      .SYNC_COUNT(SYNC_N)
   ) buck_sequencing_protection_ctrl_i (
      .sys_clk, .rstn, .clk_en, .enable_in, .undervoltage_lockout,
      .cycle_start, .pwm_off_cmd, .sync_valid, .min_on_time_slow,
      .min_off_dropout, .light_load, .boot_below_undervoltage_lockout, .vout_in_reg,
      .vout_sag, .vout_below_40pct, .vout_level, .hs_over_fixed,
      .hs_over_loop, .ls_over_limit, .temp_trip, .temp_cool,
      .high_side_switch, .low_side_switch, .diode_emulation,
      .forced_pwm_mode, .hiccup_enabled, .reference, .hop_trim,
      .spread_active, .sync_locked, .ldo_reduced_limit, .soft_start_busy
   );
   buck_load_model buck_load_model_i (
      .sys_clk, .high_side_switch, .low_side_switch,
      .hs_over_fixed, .hs_over_loop, .ls_over_limit
   );

   always #5 sys_clk = ~sys_clk;

   task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk12({11'h000, got}, {11'h000, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // One switching cycle of five clocks: start, then the loop's off command.
   task automatic pulse(input int n);
      repeat (n) begin
         cycle_start = 1'h1;
         step(1);
         cycle_start = 1'h0;
         step(2);
         pwm_off_cmd = 1'h1;
         step(1);
         pwm_off_cmd = 1'h0;
         step(1);
      end
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // The ceiling is several times the expected run length.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      step(1);
      chk1(high_side_switch, 1'h0);
      chk1(low_side_switch, 1'h0);
      chk12(reference, 12'h000);
      chk12({8'h00, hop_trim}, 12'h008);
      chk1(hiccup_enabled, 1'h0);
      rstn = 1'h1;
      enable_in = 1'h1;
      step(4);
      chk1(soft_start_busy, 1'h0);
      undervoltage_lockout = 1'h0;
      step(4);
      chk1(soft_start_busy, 1'h1);
      chk1(diode_emulation, 1'h1);
      chk1(hiccup_enabled, 1'h0);
      boot_below_undervoltage_lockout = 1'h1;
      step(2);
      cycle_start = 1'h1;
      for (int i = 0; i < 4 && low_side_switch !== 1'h1; i++) begin
         step(1);
         cycle_start = 1'h0;
         chk1(high_side_switch, 1'h0);
      end
      chk1(low_side_switch, 1'h1);
      boot_below_undervoltage_lockout = 1'h0;
      pulse(8);
      vout_in_reg = 1'h1;
      step(4);
      chk1(soft_start_busy, 1'h0);
      chk1(forced_pwm_mode, 1'h1);
      chk1(hiccup_enabled, 1'h1);
      foreach (rows[i]) begin
         {light_load, min_on_time_slow, min_off_dropout} = rows[i][3:1];
         pulse(2);
         chk1(spread_active, rows[i].exp);
      end
      {light_load, min_on_time_slow, min_off_dropout} = 3'h0;
      vout_in_reg = 1'h0;
      vout_level = 12'h400;
      vout_sag = 1'h1;
      for (int i = 0; i < 8 && reference !== 12'h429; i++) step(1);
      chk12(reference, 12'h429);
      chk1(forced_pwm_mode, 1'h1);
      vout_sag = 1'h0;
      step(SS2_N);
      vout_level = 12'h100;
      vout_below_40pct = 1'h1;
      step(2);
      pulse(127);
      vout_below_40pct = 1'h0;
      step(2);
      pulse(1);
      vout_below_40pct = 1'h1;
      step(2);
      pulse(127);
      step(20);
      chk1(soft_start_busy, 1'h0);
      pulse(1);
      step(2);
      cycle_start = 1'h1;
      step(1);
      cycle_start = 1'h0;
      chk1(high_side_switch, 1'h0);
      chk1(low_side_switch, 1'h0);
      step(HW_N - 30);
      chk1(soft_start_busy, 1'h0);
      for (int i = 0; i < 80 && soft_start_busy !== 1'h1; i++) step(1);
      chk1(soft_start_busy, 1'h1);
      vout_below_40pct = 1'h0;
      step(SS_N);
      chk1(reference >= 12'hE66, 1'h1);
      step(SS2_N - SS_N + 20);
      chk1(soft_start_busy, 1'h0);
      chk1(hiccup_enabled, 1'h1);
      temp_trip = 1'h1;
      temp_cool = 1'h0;
      step(4);
      chk1(ldo_reduced_limit, 1'h1);
      cycle_start = 1'h1;
      step(1);
      cycle_start = 1'h0;
      chk1(high_side_switch, 1'h0);
      chk1(low_side_switch, 1'h0);
      temp_trip = 1'h0;
      step(4);
      chk1(soft_start_busy, 1'h0);
      temp_cool = 1'h1;
      for (int i = 0; i < 8 && soft_start_busy !== 1'h1; i++) step(1);
      chk1(soft_start_busy, 1'h1);
      chk1(ldo_reduced_limit, 1'h0);
      vout_in_reg = 1'h1;
      step(4);
      sync_valid = 1'h1;
      pulse(SYNC_N - 4);
      chk1(sync_locked, 1'h0);
      pulse(8);
      chk1(sync_locked, 1'h1);
      chk1(spread_active, 1'h0);
      chk1(forced_pwm_mode, 1'h1);
      clk_en = 1'h0;
      sync_valid = 1'h0;
      temp_trip = 1'h1;
      step(4);
      chk1(sync_locked, 1'h1);
      chk1(ldo_reduced_limit, 1'h0);
      temp_trip = 1'h0;
      clk_en = 1'h1;
      rstn = 1'h0;
      step(1);
      chk1(high_side_switch, 1'h0);
      chk12(reference, 12'h000);
      rstn = 1'h1;
      step(2);
      chk1(soft_start_busy, 1'h1);
      close_out();
   end
endmodule
